// ==== rtl/ecl_apb.sv ====
// APB slave handshake with one wait state, held off until loading ends.
`timescale 1ns/1ps
module ecl_apb (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB request.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // APB answer.
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Register file side.
    input wire logic load_done,
    input wire logic hit,
    input wire logic [31:0] rd_data,
    output logic wr_en
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && load_done && !pready) begin
            pready <= 1'b1;
            prdata <= (hit && !pwrite) ? rd_data : 32'h0000_0000;
            pslverr <= !hit;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    assign wr_en = psel && penable && pready && pwrite && !pslverr;
endmodule

// ==== rtl/ecl_fetch.sv ====
// Sequencer that reads the start-up words one after another.
`timescale 1ns/1ps
`include "ecl_params.svh"
module ecl_fetch (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Start-up memory word port.
    output logic ee_req,
    output logic [7:0] ee_addr,
    input wire logic ee_ack,
    input wire logic [15:0] ee_rdata,
    // Delivered words.
    output logic word_valid,
    output logic [2:0] word_idx,
    output logic [15:0] word,
    output logic load_done
);
    ecl_pkg::ecl_fetch_state_t state;
    logic [2:0] idx;

    // ------------------------------------------------------------------------
    // Address of each word in the sequence.
    // ------------------------------------------------------------------------
    function automatic logic [7:0] addr_of(input logic [2:0] i);
        logic [7:0] a;
        a = `ECL_EE_SLOT3;
        unique case (i)
            3'h0: a = `ECL_EE_SLOT3;
            3'h1: a = `ECL_EE_BUDGET0;
            3'h2: a = `ECL_EE_BUDGET1;
            3'h3: a = `ECL_EE_BUDGET2;
            3'h4: a = `ECL_EE_BUDGET3;
            3'h5: a = `ECL_EE_PM0;
            default: a = `ECL_EE_PM1;
        endcase
        return a;
    endfunction

    assign ee_req = (state == ecl_pkg::FETCH_REQ);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ecl_pkg::FETCH_REQ;
            idx <= 3'h0;
            ee_addr <= `ECL_EE_SLOT3;
        end else if (state == ecl_pkg::FETCH_REQ && ee_ack) begin
            if (idx == `ECL_WORD_LAST) begin
                state <= ecl_pkg::FETCH_DONE;
            end else begin
                idx <= idx + 3'h1;
                ee_addr <= addr_of(idx + 3'h1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_valid <= 1'b0;
            word_idx <= 3'h0;
            word <= 16'h0000;
            load_done <= 1'b0;
        end else begin
            word_valid <= ee_req && ee_ack;
            if (ee_req && ee_ack) begin
                word_idx <= idx;
                word <= ee_rdata;
            end
            load_done <= (state == ecl_pkg::FETCH_DONE) && !word_valid;
        end
    end
endmodule

// ==== rtl/ecl_loader.sv ====
// Start-up loader that scatters configuration words into per-port register fields.
//
// What this block does
// - Word 66h bit 0 sets port 3 offset C0h bit 24, slot implemented.
// - Slot word bit 1 sets port 3 offset D0h bit 28, reference clock from the connector.
// - Slot word bit 2 sets port 3 offset 40h bit 21, device-specific initialization required.
// - Slot word bit 3 sets port 3 offset 144h bit 4, VC1 counted as low-priority.
// - Slot word bits 6:4 set port 3 offset CCh bits 26:24, the logical port number.
// - Slot word bits 15:9 set port 3 offset 154h bits 7:1, traffic classes mapped to VC0.
// - Power budget words for ports 0 to 3 come from 70h, 72h, 74h and 76h with one layout.
// - Budget bits 7:0 go to 214h bits 7:0 and bits 9:8 to 214h bits 9:8.
// - Budget bits 11:10 go to 214h bits 14:13 and bit 15 to 218h bit 0.
// - Word 80h bits 5:0 go to port 0 offset 74h bits 13:8.
// - Power-management word bit 6 goes to 74h bit 14, receiver polarity disabled.
// - Power-management word bit 7 goes to 70h bit 31, VGA decode enabled.
// - Power-management word bits 15:8 go to 88h bits 31:24 of vendor_control_reg5.
// - Word 82h fills the port 1 registers with the port 0 layout.
`timescale 1ns/1ps
`include "ecl_params.svh"
module ecl_loader (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB register bus; paddr[13:12] selects the port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Start-up memory word port.
    output logic ee_req,
    output logic [7:0] ee_addr,
    input wire logic ee_ack,
    input wire logic [15:0] ee_rdata,
    // Loader status.
    output logic load_done,
    // Slot fields, one entry per port.
    output logic [3:0] slot_impl,
    output logic [3:0] conn_clk,
    output logic [3:0] dev_init,
    output logic [3:0] lpvc_vc1,
    output logic [3:0][2:0] port_num,
    output logic [3:0][6:0] tc_map,
    // Power budget fields, one entry per port.
    output logic [3:0][7:0] base_power,
    output logic [3:0][1:0] data_scale,
    output logic [3:0][1:0] pm_state,
    output logic [3:0] sys_alloc,
    // Power-management fields, one entry per port.
    output logic [3:0][5:0] pm_ctl,
    output logic [3:0] rx_pol_dis,
    output logic [3:0] vga_en,
    output logic [3:0][7:0] vendor_control_reg5
);
    logic word_valid;
    logic [2:0] word_idx;
    logic [15:0] word;
    logic wr_en;
    logic hit;
    logic [31:0] rd_data;
    ecl_pkg::ecl_port_t wport;
    logic [11:0] woff;

    assign wport = paddr[13:12];
    assign woff = paddr[11:0];

    // ------------------------------------------------------------------------
    // Word fetch and bus handshake.
    // ------------------------------------------------------------------------
    ecl_fetch u_fetch (
        .pclk(pclk),
        .presetn(presetn),
        .ee_req(ee_req),
        .ee_addr(ee_addr),
        .ee_ack(ee_ack),
        .ee_rdata(ee_rdata),
        .word_valid(word_valid),
        .word_idx(word_idx),
        .word(word),
        .load_done(load_done)
    );

    ecl_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .load_done(load_done),
        .hit(hit),
        .rd_data(rd_data),
        .wr_en(wr_en)
    );

    // ------------------------------------------------------------------------
    // Write qualifier for one register and byte lane.
    // ------------------------------------------------------------------------
    function automatic logic wr_at(input logic en, input logic [11:0] off, input logic [11:0] reg_off,
                                   input logic [3:0] strb, input int lane);
        return en && (off == reg_off) && strb[lane];
    endfunction

    // ------------------------------------------------------------------------
    // Slot word, loaded into port 3 only.
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_impl <= 4'h0;
            conn_clk <= 4'h0;
            dev_init <= 4'h0;
            lpvc_vc1 <= 4'h0;
            port_num <= '0;
            tc_map <= '0;
        end else if (word_valid && word_idx == `ECL_IDX_SLOT3) begin
            slot_impl[3] <= word[0];
            conn_clk[3] <= word[1];
            dev_init[3] <= word[2];
            lpvc_vc1[3] <= word[3];
            port_num[3] <= word[6:4];
            tc_map[3] <= word[15:9];
        end else begin
            if (wr_at(wr_en, woff, `ECL_OFF_SLOT, pstrb, 3)) slot_impl[wport] <= pwdata[`ECL_B_SLOT];
            if (wr_at(wr_en, woff, `ECL_OFF_CLK, pstrb, 3)) conn_clk[wport] <= pwdata[`ECL_B_CLK];
            if (wr_at(wr_en, woff, `ECL_OFF_PMCAP, pstrb, 2)) dev_init[wport] <= pwdata[`ECL_B_DSI];
            if (wr_at(wr_en, woff, `ECL_OFF_LPVC, pstrb, 0)) lpvc_vc1[wport] <= pwdata[`ECL_B_LPVC];
            if (wr_at(wr_en, woff, `ECL_OFF_PNUM, pstrb, 3)) port_num[wport] <= pwdata[`ECL_B_PNUM +: 3];
            if (wr_at(wr_en, woff, `ECL_OFF_TCMAP, pstrb, 0)) tc_map[wport] <= pwdata[`ECL_B_TCMAP +: 7];
        end
    end

    // ------------------------------------------------------------------------
    // Power budget words, one per port.
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_power <= '0;
            data_scale <= '0;
            pm_state <= '0;
            sys_alloc <= 4'h0;
        end else if (word_valid && word_idx >= `ECL_IDX_BUDGET0 && word_idx <= `ECL_IDX_BUDGET3) begin
            base_power[2'(word_idx - `ECL_IDX_BUDGET0)] <= word[7:0];
            data_scale[2'(word_idx - `ECL_IDX_BUDGET0)] <= word[9:8];
            pm_state[2'(word_idx - `ECL_IDX_BUDGET0)] <= word[11:10];
            sys_alloc[2'(word_idx - `ECL_IDX_BUDGET0)] <= word[15];
        end else begin
            if (wr_at(wr_en, woff, `ECL_OFF_BUDGET, pstrb, 0)) base_power[wport] <= pwdata[`ECL_B_BASE +: 8];
            if (wr_at(wr_en, woff, `ECL_OFF_BUDGET, pstrb, 1)) begin
                data_scale[wport] <= pwdata[`ECL_B_SCALE +: 2];
                pm_state[wport] <= pwdata[`ECL_B_PMST +: 2];
            end
            if (wr_at(wr_en, woff, `ECL_OFF_ALLOC, pstrb, 0)) sys_alloc[wport] <= pwdata[`ECL_B_ALLOC];
        end
    end

    // ------------------------------------------------------------------------
    // Power-management words for ports 0 and 1.
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_ctl <= '0;
            rx_pol_dis <= 4'h0;
            vga_en <= 4'h0;
            vendor_control_reg5 <= '0;
        end else if (word_valid && (word_idx == `ECL_IDX_PM0 || word_idx == `ECL_IDX_PM1)) begin
            pm_ctl[{1'b0, word_idx == `ECL_IDX_PM1}] <= word[5:0];
            rx_pol_dis[{1'b0, word_idx == `ECL_IDX_PM1}] <= word[6];
            vga_en[{1'b0, word_idx == `ECL_IDX_PM1}] <= word[7];
            vendor_control_reg5[{1'b0, word_idx == `ECL_IDX_PM1}] <= word[15:8];
        end else begin
            if (wr_at(wr_en, woff, `ECL_OFF_PMCTL, pstrb, 1)) begin
                pm_ctl[wport] <= pwdata[`ECL_B_PMCTL +: 6];
                rx_pol_dis[wport] <= pwdata[`ECL_B_RXPOL];
            end
            if (wr_at(wr_en, woff, `ECL_OFF_VGA, pstrb, 3)) vga_en[wport] <= pwdata[`ECL_B_VGA];
            if (wr_at(wr_en, woff, `ECL_OFF_VCR5, pstrb, 3)) vendor_control_reg5[wport] <= pwdata[`ECL_B_VCR5 +: 8];
        end
    end

    // ------------------------------------------------------------------------
    // Read decode; bits outside the fields read as zero.
    // ------------------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        hit = 1'b1;
        unique case (woff)
            `ECL_OFF_SLOT: rd_data[`ECL_B_SLOT] = slot_impl[wport];
            `ECL_OFF_CLK: rd_data[`ECL_B_CLK] = conn_clk[wport];
            `ECL_OFF_PMCAP: rd_data[`ECL_B_DSI] = dev_init[wport];
            `ECL_OFF_LPVC: rd_data[`ECL_B_LPVC] = lpvc_vc1[wport];
            `ECL_OFF_PNUM: rd_data[`ECL_B_PNUM +: 3] = port_num[wport];
            `ECL_OFF_TCMAP: rd_data[`ECL_B_TCMAP +: 7] = tc_map[wport];
            `ECL_OFF_BUDGET: begin
                rd_data[`ECL_B_BASE +: 8] = base_power[wport];
                rd_data[`ECL_B_SCALE +: 2] = data_scale[wport];
                rd_data[`ECL_B_PMST +: 2] = pm_state[wport];
            end
            `ECL_OFF_ALLOC: rd_data[`ECL_B_ALLOC] = sys_alloc[wport];
            `ECL_OFF_PMCTL: begin
                rd_data[`ECL_B_PMCTL +: 6] = pm_ctl[wport];
                rd_data[`ECL_B_RXPOL] = rx_pol_dis[wport];
            end
            `ECL_OFF_VGA: rd_data[`ECL_B_VGA] = vga_en[wport];
            `ECL_OFF_VCR5: rd_data[`ECL_B_VCR5 +: 8] = vendor_control_reg5[wport];
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Checks and coverage.
    // ------------------------------------------------------------------------
    logic load_q;
    logic [2:0] idx_q;
    logic [15:0] word_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q <= 1'b0;
            idx_q <= 3'h0;
            word_q <= 16'h0000;
        end else begin
            load_q <= word_valid;
            idx_q <= word_idx;
            word_q <= word;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_slot_flags: assert property (load_q && idx_q == `ECL_IDX_SLOT3 |-> slot_impl[3] == word_q[0]
        && conn_clk[3] == word_q[1] && dev_init[3] == word_q[2] && lpvc_vc1[3] == word_q[3])
        else $error("Port 3 slot flags differ from the slot word.");
    a_slot_fields: assert property (load_q && idx_q == `ECL_IDX_SLOT3 |->
        port_num[3] == word_q[6:4] && tc_map[3] == word_q[15:9])
        else $error("Port 3 port number or traffic class map differ from the slot word.");
    a_slot_addr: assert property (ee_req && ee_addr == `ECL_EE_SLOT3 && ee_ack |=>
        word_valid && word_idx == `ECL_IDX_SLOT3)
        else $error("Word from the slot address was not delivered as the slot word.");
    a_budget_low: assert property (load_q && idx_q == `ECL_IDX_BUDGET0 |->
        base_power[0] == word_q[7:0] && data_scale[0] == word_q[9:8])
        else $error("Port 0 base power or data scale differ from the budget word.");
    a_budget_high: assert property (load_q && idx_q == `ECL_IDX_BUDGET3 |->
        pm_state[3] == word_q[11:10] && sys_alloc[3] == word_q[15])
        else $error("Port 3 budget state or allocation differ from the budget word.");
    a_budget_addr: assert property (ee_req && ee_ack && ee_addr == `ECL_EE_BUDGET3 |=> ##1
        base_power[3] == $past(ee_rdata[7:0], 2))
        else $error("Word at the port 3 budget address did not reach port 3.");
    a_pm0_map: assert property (load_q && idx_q == `ECL_IDX_PM0 |-> pm_ctl[0] == word_q[5:0]
        && rx_pol_dis[0] == word_q[6] && vga_en[0] == word_q[7])
        else $error("Port 0 power-management fields differ from the word.");
    a_vcr5_byte: assert property (load_q && idx_q == `ECL_IDX_PM0 |-> vendor_control_reg5[0] == word_q[15:8])
        else $error("Port 0 vendor control byte differs from the word.");
    a_pm1_map: assert property (load_q && idx_q == `ECL_IDX_PM1 |-> pm_ctl[1] == word_q[5:0]
        && rx_pol_dis[1] == word_q[6] && vga_en[1] == word_q[7] && vendor_control_reg5[1] == word_q[15:8])
        else $error("Port 1 power-management fields differ from the word.");
    a_rx_pol_sep: assert property (load_q && idx_q == `ECL_IDX_PM1 |-> $stable(rx_pol_dis[0]))
        else $error("Loading port 1 disturbed port 0 polarity control.");
    a_vga_sep: assert property (load_q && idx_q == `ECL_IDX_PM0 |-> $stable(vga_en[1]))
        else $error("Loading port 0 disturbed port 1 VGA decode.");
    a_no_early_ready: assert property (!load_done |-> !pready)
        else $error("Bus answered before loading ended.");
    a_done_sticks: assert property (load_done |=> load_done && !ee_req)
        else $error("Loader restarted after it was done.");
    a_fields_hold: assert property (load_done && !wr_en |=> $stable(vga_en) && $stable(base_power)
        && $stable(tc_map) && $stable(pm_ctl))
        else $error("A field changed without a software write.");
    a_ready_one: assert property (pready |=> !pready)
        else $error("Ready stood for more than one cycle.");

    c_load_end: cover property (!load_done ##1 load_done);
    c_write_vga: cover property (wr_en && woff == `ECL_OFF_VGA);
    c_read_budget: cover property (pready && !pwrite && woff == `ECL_OFF_BUDGET);
    c_unmapped: cover property (pready && pslverr);
endmodule

// ==== rtl/ecl_params.svh ====
// Constants of the start-up configuration loader: word addresses, offsets, bit positions.
`ifndef ECL_PARAMS_SVH
`define ECL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Start-up memory word addresses.
// ----------------------------------------------------------------------------
`define ECL_EE_SLOT3 8'h66
`define ECL_EE_BUDGET0 8'h70
`define ECL_EE_BUDGET1 8'h72
`define ECL_EE_BUDGET2 8'h74
`define ECL_EE_BUDGET3 8'h76
`define ECL_EE_PM0 8'h80
`define ECL_EE_PM1 8'h82
`define ECL_WORD_LAST 3'h6

// ----------------------------------------------------------------------------
// Word slots in the load sequence.
// ----------------------------------------------------------------------------
`define ECL_IDX_SLOT3 3'h0
`define ECL_IDX_BUDGET0 3'h1
`define ECL_IDX_BUDGET3 3'h4
`define ECL_IDX_PM0 3'h5
`define ECL_IDX_PM1 3'h6

// ----------------------------------------------------------------------------
// Configuration offsets of each port.
// ----------------------------------------------------------------------------
`define ECL_OFF_PMCAP 12'h040
`define ECL_OFF_VGA 12'h070
`define ECL_OFF_PMCTL 12'h074
`define ECL_OFF_VCR5 12'h088
`define ECL_OFF_SLOT 12'h0C0
`define ECL_OFF_PNUM 12'h0CC
`define ECL_OFF_CLK 12'h0D0
`define ECL_OFF_LPVC 12'h144
`define ECL_OFF_TCMAP 12'h154
`define ECL_OFF_BUDGET 12'h214
`define ECL_OFF_ALLOC 12'h218

// ----------------------------------------------------------------------------
// Field positions inside the 32-bit registers.
// ----------------------------------------------------------------------------
`define ECL_B_SLOT 24
`define ECL_B_CLK 28
`define ECL_B_DSI 21
`define ECL_B_LPVC 4
`define ECL_B_PNUM 24
`define ECL_B_TCMAP 1
`define ECL_B_BASE 0
`define ECL_B_SCALE 8
`define ECL_B_PMST 13
`define ECL_B_ALLOC 0
`define ECL_B_PMCTL 8
`define ECL_B_RXPOL 14
`define ECL_B_VGA 31
`define ECL_B_VCR5 24

`endif

// ==== rtl/ecl_pkg.sv ====
// Types shared by the start-up configuration loader.
package ecl_pkg;
    typedef enum logic [0:0] {FETCH_REQ, FETCH_DONE} ecl_fetch_state_t;
    typedef logic [1:0] ecl_port_t;
endpackage

// ==== sim/ecl_ee_model.sv ====
// Start-up memory model that answers word requests from a fixed table.
`timescale 1ns/1ps
`include "ecl_params.svh"
module ecl_ee_model #(
    parameter logic [6:0][15:0] WORDS = '0
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Word port.
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    output logic ee_ack,
    output logic [15:0] ee_rdata
);
    logic [2:0] idx;
    logic [1:0] wait_cnt;
    // Maps the requested address to its table entry.
    always_comb begin
        case (ee_addr)
            `ECL_EE_BUDGET0: idx = 3'h1;
            `ECL_EE_BUDGET1: idx = 3'h2;
            `ECL_EE_BUDGET2: idx = 3'h3;
            `ECL_EE_BUDGET3: idx = 3'h4;
            `ECL_EE_PM0: idx = 3'h5;
            `ECL_EE_PM1: idx = 3'h6;
            default: idx = 3'h0;
        endcase
    end
    // Odd entries answer after two idle cycles; idle data toggles every cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ee_ack <= 1'b0;
            ee_rdata <= 16'hFFFF;
            wait_cnt <= 2'h0;
        end else if (ee_ack) begin
            ee_ack <= 1'b0;
            ee_rdata <= ~ee_rdata;
            wait_cnt <= 2'h0;
        end else if (ee_req && (!idx[0] || wait_cnt == 2'h2)) begin
            ee_ack <= 1'b1;
            ee_rdata <= WORDS[idx];
        end else begin
            ee_rdata <= ~ee_rdata;
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking testbench of the start-up configuration loader.
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0][15:0] W = {16'h5A4E, 16'hC3B5, 16'h1D9E, 16'hF4C1, 16'h0567, 16'h8A3C, 16'hB55B};
    localparam logic [10:0][11:0] OFFS = {12'h0C0, 12'h0D0, 12'h040, 12'h144, 12'h0CC, 12'h154, 12'h214,
        12'h218, 12'h074, 12'h070, 12'h088};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ee_req, ee_ack, load_done;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd, ex;
    logic [3:0] pstrb, slot_impl;
    logic [7:0] ee_addr;
    logic [15:0] ee_rdata;
    logic [3:0][2:0] port_num;
    logic [3:0][7:0] base_power, vendor_control_reg5;
    logic err;
    int fail_count, total_checks, cycles;
    ecl_loader dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_rdata(ee_rdata), .load_done(load_done),
        .slot_impl(slot_impl), .conn_clk(), .dev_init(), .lpvc_vc1(), .port_num(port_num), .tc_map(),
        .base_power(base_power), .data_scale(), .pm_state(), .sys_alloc(), .pm_ctl(), .rx_pol_dis(),
        .vga_en(), .vendor_control_reg5(vendor_control_reg5));
    ecl_ee_model #(.WORDS(W)) ee_u (.pclk(pclk), .presetn(presetn), .ee_req(ee_req), .ee_addr(ee_addr),
        .ee_ack(ee_ack), .ee_rdata(ee_rdata));
    // ------------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------------
    function automatic logic [31:0] exp_reg(int p, logic [11:0] off);
        logic [15:0] s, b, m;
        s = (p == 3) ? W[0] : 16'h0000;
        b = W[1 + p];
        m = (p < 2) ? W[5 + p] : 16'h0000;
        case (off)
            12'h0C0: return 32'(s[0]) << 24;
            12'h0D0: return 32'(s[1]) << 28;
            12'h040: return 32'(s[2]) << 21;
            12'h144: return 32'(s[3]) << 4;
            12'h0CC: return 32'(s[6:4]) << 24;
            12'h154: return 32'(s[15:9]) << 1;
            12'h214: return (32'(b[11:10]) << 13) | 32'(b[9:0]);
            12'h218: return 32'(b[15]);
            12'h074: return 32'(m[6:0]) << 8;
            12'h070: return 32'(m[7]) << 31;
            12'h088: return 32'(m[15:8]) << 24;
            default: return 32'h0000_0000;
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        total_checks++;
        if (seen !== expd) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 1000);
        if (n >= 1000) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // Clock and timeout.
    // ------------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    // ------------------------------------------------------------------------
    // Tests.
    // ------------------------------------------------------------------------
    initial begin
        fail_count = 0;
        total_checks = 0;
        cycles = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        repeat (10) @(posedge pclk);
        check(32'(load_done), 32'h0000_0000);
        check(32'(vendor_control_reg5[0]), 32'h0000_0000);
        presetn <= 1'b1;
        apb(1'b0, {2'd3, 12'h0C0}, 32'h0000_0000, 4'h0);
        check(32'(load_done), 32'h0000_0001);
        check(rd, exp_reg(3, 12'h0C0));
        $display("test early access done");
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 11; i++) begin
                apb(1'b0, {2'(p), OFFS[i]}, 32'h0000_0000, 4'h0);
                check(rd, exp_reg(p, OFFS[i]));
                check(32'(err), 32'h0000_0000);
            end
        end
        check(32'(slot_impl), 32'(W[0][0]) << 3);
        check(32'(port_num[3]), 32'(W[0][6:4]));
        check(32'(base_power[2]), 32'(W[3][7:0]));
        check(32'(vendor_control_reg5[1]), 32'(W[6][15:8]));
        $display("test load scan done");
        apb(1'b1, {2'd2, 12'h214}, 32'hFFFF_FFFF, 4'h1);
        apb(1'b0, {2'd2, 12'h214}, 32'h0000_0000, 4'h0);
        ex = (exp_reg(2, 12'h214) & 32'hFFFF_FF00) | 32'h0000_00FF;
        check(rd, ex);
        apb(1'b1, {2'd0, 12'h074}, 32'hFFFF_FFFF, 4'h0);
        apb(1'b0, {2'd0, 12'h074}, 32'h0000_0000, 4'h0);
        check(rd, exp_reg(0, 12'h074));
        apb(1'b1, {2'd1, 12'h088}, 32'h1200_0000, 4'h8);
        apb(1'b0, {2'd1, 12'h088}, 32'h0000_0000, 4'h0);
        check(rd, 32'h1200_0000);
        $display("test rewrite done");
        apb(1'b1, {2'd0, 12'h004}, 32'hFFFF_FFFF, 4'hF);
        check(32'(err), 32'h0000_0001);
        apb(1'b0, {2'd0, 12'h004}, 32'h0000_0000, 4'h0);
        check(32'(err), 32'h0000_0001);
        check(rd, 32'h0000_0000);
        $display("test unmapped done");
        results();
    end
endmodule
